// ===== design/eab_consts.svh
/*
  Offsets, field positions, codes and reset values of the external area bus timing block.
  Assumes an 8-bit APB byte address and 32-bit register words.
*/
`ifndef EAB_CONSTS_SVH
`define EAB_CONSTS_SVH
`define EAB_OFS_BCR0      8'h00
`define EAB_OFS_WCR0      8'h0c
`define EAB_OFS_STATUS    8'h18
`define EAB_BCR_IWS       23:22
`define EAB_BCR_IRO       20:19
`define EAB_BCR_IRS       17:16
`define EAB_BCR_TYPE      15:12
`define EAB_BCR_WIDTH     10:9
`define EAB_WCR_BAS       20
`define EAB_WCR_WW        18:16
`define EAB_WCR_SW        12:11
`define EAB_WCR_WR        10:7
`define EAB_WCR_WM        6
`define EAB_WCR_HW        1:0
`define EAB_BCR_MASK      32'h00dbf600
`define EAB_WCR0_MASK     32'h00001fc3
`define EAB_WCR3_MASK     32'h001007c0
`define EAB_WCR4_MASK     32'h00171fc3
`define EAB_BCR_RST       32'h00db0600
`define EAB_WCR_RST       32'h00000500
`define EAB_TYPE_NORMAL   4'h0
`define EAB_TYPE_BSRAM    4'h3
`define EAB_TYPE_SDRAM    4'h4
`define EAB_TYPE_PCMCIA   4'h5
`define EAB_WIDTH_8       2'b01
`define EAB_WIDTH_16      2'b10
`define EAB_AREA_COUNT    3
`endif

// ===== design/eab_ctrl.sv
/*
  Per-area configuration registers and access timing engine for areas 0, 3 and 4.
  Assumes an APB master, a single-request user port and asynchronous external memory.
*/
// Overview of operation
// - Read then write same area: idle gap.
// - Read then read other area: idle gap.
// - Read then read same area: idle gap.
// - Type field picks normal or byte-select SRAM; other types are refused.
// - Width code 01 is 8, 10 is 16.
// - Area 0 width comes from the pin.
// - Wait layout follows the area number.
// - Setup delays strobes by whole-cycle steps.
// - Access wait code maps to cycle count.
// - Wait mask gates the external wait input.
// - Hold delays select negation after strobes.
// - Byte role bit swaps enable and write strobes.
// - Area 4 write wait overrides read wait.
// - Reserved bits read zero.
// - Width pin high gives 8, low 16.
`timescale 1ns/1ps
`include "eab_consts.svh"
module eab_ctrl #(
  parameter int ADDR_W = 26,
  parameter int DATA_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              area0_width_pin,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [1:0]        req_area,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_bytes,
  output logic                   req_ready,
  output logic                   resp_valid,
  output logic [DATA_W-1:0]      resp_rdata,
  output logic                   resp_error,
  output logic [ADDR_W-1:0]      ext_addr,
  output logic [DATA_W-1:0]      ext_wdata,
  output logic                   ext_wdata_oe,
  input  wire logic [DATA_W-1:0] ext_rdata,
  input  wire logic              ext_wait,
  output logic [2:0]             area_chip_select_n,
  output logic                   rd_n,
  output logic                   rd_wr_n,
  output logic [1:0]             byte_enable_n
);

  // Access wait code to cycle count; prohibited codes fall back to the longest count.
  function automatic logic [4:0] wait_cycles(input logic [3:0] code);
    case (code)
      4'h7:    wait_cycles = 5'h08;
      4'h8:    wait_cycles = 5'h0a;
      4'h9:    wait_cycles = 5'h0c;
      4'ha:    wait_cycles = 5'h0e;
      4'hb:    wait_cycles = 5'h12;
      4'hc:    wait_cycles = 5'h18;
      4'hd, 4'he, 4'hf: wait_cycles = 5'h18;
      default: wait_cycles = {1'b0, code};
    endcase
  endfunction

  // Idle field code to idle bus cycles: none, 1, 2 or 4.
  function automatic logic [2:0] idle_cycles(input logic [1:0] code);
    idle_cycles = (code == 2'b11) ? 3'h4 : {1'b0, code};
  endfunction

  logic [1:0]        rst_sync;
  logic              rst_n;
  logic              width_cap_done;
  logic              area0_8bit;
  logic [31:0]       bcr [`EAB_AREA_COUNT];
  logic [31:0]       wcr [`EAB_AREA_COUNT];
  logic [31:0]       bcr0_view;
  eab_pkg::eab_state_t state;
  eab_pkg::eab_state_t next_state;
  logic [5:0]        cnt;
  logic [5:0]        next_cnt;
  logic [1:0]        cur_area;
  logic              cur_write;
  logic              cur_bsram;
  logic              cur_bas;
  logic              cur_wm;
  logic [1:0]        cur_bytes;
  logic [1:0]        cur_hw;
  logic [1:0]        cur_sw;
  logic [4:0]        cur_wait;
  logic              last_valid;
  logic              last_read;
  logic [1:0]        last_area;

  // Reset is released through two flip-flops; the rest of the block uses the copy.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // The width pin is caught once, in the first enabled cycle after reset release.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_cap_done <= 1'b0;
      area0_8bit     <= 1'b0;
    end else if (clk_en && !width_cap_done) begin
      width_cap_done <= 1'b1;
      area0_8bit     <= area0_width_pin;
    end
  end

  // APB decode: three bus control words, three wait control words, one status word.
  wire        apb_word   = (paddr[1:0] == 2'b00);
  wire        sel_bcr    = apb_word && (paddr < `EAB_OFS_WCR0);
  wire        sel_wcr    = apb_word && (paddr >= `EAB_OFS_WCR0) && (paddr < `EAB_OFS_STATUS);
  wire        sel_status = (paddr == `EAB_OFS_STATUS);
  wire        addr_ok    = sel_bcr || sel_wcr || sel_status;
  wire [1:0]  bcr_idx    = paddr[3:2];
  wire [7:0]  wcr_off    = paddr - `EAB_OFS_WCR0;
  wire [1:0]  wcr_idx    = wcr_off[3:2];
  wire        apb_wr     = psel && penable && pwrite && addr_ok;
  wire [31:0] wcr_mask [`EAB_AREA_COUNT] = '{`EAB_WCR0_MASK, `EAB_WCR3_MASK, `EAB_WCR4_MASK};
  wire        busy       = (state != eab_pkg::ST_IDLE);

  // One bus control and one wait control register per area; masks drop reserved bits.
  for (genvar gi = 0; gi < `EAB_AREA_COUNT; gi++) begin : g_area
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        bcr[gi] <= `EAB_BCR_RST;
        wcr[gi] <= `EAB_WCR_RST;
      end else if (clk_en && apb_wr) begin
        if (sel_bcr && bcr_idx == 2'(gi)) begin
          bcr[gi] <= pwdata & `EAB_BCR_MASK;
        end
        if (sel_wcr && wcr_idx == 2'(gi)) begin
          wcr[gi] <= pwdata & wcr_mask[gi];
        end
      end
    end
  end

  // Area 0 width bits show the pin level, whatever was written; the live pin stands in
  // until it is caught, so a read in the capture cycle is already right.
  wire   area0_8bit_view = width_cap_done ? area0_8bit : area0_width_pin;
  assign bcr0_view = {bcr[0][31:11], area0_8bit_view ? `EAB_WIDTH_8 : `EAB_WIDTH_16,
                      bcr[0][8:0]};

  wire [31:0] status_view = {29'h0, width_cap_done, area0_8bit, busy};
  wire [31:0] bcr_view    = (bcr_idx == 2'd0) ? bcr0_view :
                            (bcr_idx < 2'd3) ? bcr[bcr_idx] : 32'h0;
  wire [31:0] wcr_view    = (wcr_idx < 2'd3) ? wcr[wcr_idx] : 32'h0;
  wire [31:0] rd_mux      = sel_bcr ? bcr_view : sel_wcr ? wcr_view :
                            sel_status ? status_view : 32'h0;

  // Read data is latched in the setup phase so the access phase completes at once.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (clk_en && psel && !penable) begin
      prdata <= rd_mux;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Settings of the requested area, valid in the cycle a request is taken.
  wire [31:0] req_bcr   = (req_area == 2'd0) ? bcr[0] : (req_area == 2'd1) ? bcr[1] : bcr[2];
  wire [31:0] req_wcr   = (req_area == 2'd0) ? wcr[0] : (req_area == 2'd1) ? wcr[1] : wcr[2];
  wire [3:0]  req_type  = req_bcr[`EAB_BCR_TYPE];
  wire        req_bsram = (req_type == `EAB_TYPE_BSRAM);
  wire        type_ok   = (req_type == `EAB_TYPE_NORMAL) || req_bsram;
  wire        area_ok   = (req_area != 2'd3);
  wire        req_8bit  = (req_area == 2'd0) ? area0_8bit :
                          (req_bcr[`EAB_BCR_WIDTH] == `EAB_WIDTH_8);
  wire [4:0]  read_wait = wait_cycles(req_wcr[`EAB_WCR_WR]);
  wire [2:0]  ww_code   = req_wcr[`EAB_WCR_WW];
  wire        use_ww    = (req_area == 2'd2) && req_write && (ww_code != 3'h0);
  wire [4:0]  req_wait  = use_ww ? {2'b00, ww_code - 3'h1} : read_wait;
  wire        has_sw_hw = (req_area != 2'd1);
  wire [1:0]  req_sw    = has_sw_hw ? req_wcr[`EAB_WCR_SW] : 2'b00;
  wire [1:0]  req_hw    = has_sw_hw ? req_wcr[`EAB_WCR_HW] : 2'b00;
  wire        req_bas   = (req_area != 2'd0) && req_wcr[`EAB_WCR_BAS];

  // Idle gap after a read, taken from the previous area's bus control word.
  wire [31:0] last_bcr  = (last_area == 2'd0) ? bcr[0] : (last_area == 2'd1) ? bcr[1] : bcr[2];
  wire        after_rd  = last_valid && last_read;
  wire        same_area = (last_area == req_area);
  wire [2:0]  gap_ws    = (after_rd && req_write && same_area) ?
                          idle_cycles(last_bcr[`EAB_BCR_IWS]) : 3'h0;
  wire [2:0]  gap_ro    = (after_rd && !req_write && !same_area) ?
                          idle_cycles(last_bcr[`EAB_BCR_IRO]) : 3'h0;
  wire [2:0]  gap_rs    = (after_rd && !req_write && same_area) ?
                          idle_cycles(last_bcr[`EAB_BCR_IRS]) : 3'h0;
  wire [2:0]  gap_ab    = (gap_ws > gap_ro) ? gap_ws : gap_ro;
  wire [2:0]  gap_max   = (gap_ab > gap_rs) ? gap_ab : gap_rs;

  assign req_ready = width_cap_done && !busy;
  wire   take      = clk_en && req_valid && req_ready;
  wire   take_ok   = take && type_ok && area_ok;
  wire   stretch   = ext_wait && !cur_wm;

  // Sequencer; every count is in half bus cycles, one half per clock.
  always_comb begin
    next_state = state;
    next_cnt   = (cnt != 6'h0) ? cnt - 6'h1 : cnt;
    case (state)
      eab_pkg::ST_IDLE: begin
        if (take_ok && gap_max != 3'h0) begin
          next_state = eab_pkg::ST_GAP;
          next_cnt   = 6'({gap_max, 1'b0}) - 6'h1;
        end else if (take_ok) begin
          next_state = eab_pkg::ST_SETUP;
          next_cnt   = 6'({req_sw, 1'b0});
        end
      end
      eab_pkg::ST_GAP: begin
        if (cnt == 6'h0) begin
          next_state = eab_pkg::ST_SETUP;
          next_cnt   = 6'({cur_sw, 1'b0});
        end
      end
      eab_pkg::ST_SETUP: begin
        if (cnt == 6'h0) begin
          next_state = eab_pkg::ST_STROBE;
          next_cnt   = {cur_wait, 1'b1};
        end
      end
      eab_pkg::ST_STROBE: begin
        if (cnt == 6'h0 && !stretch) begin
          next_state = eab_pkg::ST_HOLD;
          next_cnt   = 6'({cur_hw, 1'b0});
        end
      end
      eab_pkg::ST_HOLD: begin
        if (cnt == 6'h0) begin
          next_state = eab_pkg::ST_IDLE;
        end
      end
      default: next_state = eab_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state and counter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= eab_pkg::ST_IDLE;
      cnt   <= 6'h0;
    end else if (clk_en) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Request settings are frozen when taken so register writes cannot tear an access.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cur_area, cur_write, cur_bsram, cur_bas, cur_wm} <= 6'h0;
      {cur_bytes, cur_hw, cur_sw, cur_wait}             <= 11'h0;
      ext_addr  <= '0;
      ext_wdata <= '0;
    end else if (take_ok) begin
      cur_area  <= req_area;
      cur_write <= req_write;
      cur_bsram <= req_bsram;
      cur_bas   <= req_bas;
      cur_wm    <= req_wcr[`EAB_WCR_WM];
      cur_bytes <= req_8bit ? 2'b01 : req_bytes;
      cur_hw    <= req_hw;
      cur_sw    <= req_sw;
      cur_wait  <= req_wait;
      ext_addr  <= req_addr;
      ext_wdata <= req_wdata;
    end
  end

  // Answer to the user port and memory of the previous access for idle gaps.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {resp_valid, resp_error, last_valid, last_read} <= 4'h0;
      last_area  <= 2'h0;
      resp_rdata <= '0;
    end else if (clk_en) begin
      resp_valid <= (state == eab_pkg::ST_HOLD) && (cnt == 6'h0);
      resp_error <= take && !(type_ok && area_ok);
      if (state == eab_pkg::ST_STROBE && next_state == eab_pkg::ST_HOLD && !cur_write) begin
        resp_rdata <= ext_rdata;
      end
      if (state == eab_pkg::ST_HOLD && cnt == 6'h0) begin
        last_valid <= 1'b1;
        last_read  <= !cur_write;
        last_area  <= cur_area;
      end
    end
  end

  // External strobes, decoded from the sequencer state.
  wire active   = (state == eab_pkg::ST_SETUP) || (state == eab_pkg::ST_STROBE) ||
                  (state == eab_pkg::ST_HOLD);
  wire strobe   = (state == eab_pkg::ST_STROBE);
  wire be_on    = cur_bsram ? (cur_bas ? active : strobe) : (strobe && cur_write);
  wire wr_on    = (cur_bsram && cur_bas) ? strobe : active;
  assign rd_n          = !(strobe && !cur_write);
  assign rd_wr_n       = !(cur_write && wr_on);
  assign byte_enable_n = ~(cur_bytes & {2{be_on}});
  assign ext_wdata_oe  = active && cur_write;
  for (genvar ci = 0; ci < 3; ci++) begin : g_cs
    assign area_chip_select_n[ci] = !(active && cur_area == 2'(ci));
  end

endmodule

// ===== design/eab_pkg.sv
/*
  Types shared by the external area bus timing block.
  Assumes nothing of its surroundings.
*/
package eab_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_SETUP, ST_STROBE, ST_HOLD} eab_state_t;
endpackage

// ===== test/eab_ctrl_properties.sv
/* Port checker for eab_ctrl, bound to every instance.
   Assumes clk_en is held steady and the width pin changes only while reset is held. */
`timescale 1ns/1ps
`include "eab_consts.svh"
module eab_ctrl_properties (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        area0_width_pin,
  input wire logic        req_valid,
  input wire logic [1:0]  req_area,
  input wire logic        req_ready,
  input wire logic        resp_error,
  input wire logic        ext_wdata_oe,
  input wire logic [2:0]  area_chip_select_n,
  input wire logic        rd_n,
  input wire logic        rd_wr_n,
  input wire logic [1:0]  byte_enable_n
);
  // Any chip select active, and an APB read in its access phase.
  wire logic cs_on = ~&area_chip_select_n;
  wire logic rd_acc = psel && penable && !pwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Steps of a strobe and of a refused request.
  sequence s_strobe_min; !rd_n ##1 !rd_n; endsequence
  sequence s_refused; resp_error && &area_chip_select_n; endsequence
  property p_setup; $rose(cs_on) |-> rd_n; endproperty
  a_setup: assert property (p_setup) else $error("strobe without setup");
  property p_hold; $rose(rd_n) |-> cs_on; endproperty
  a_hold: assert property (p_hold) else $error("select ended with strobe");
  property p_strobe; $fell(rd_n) |-> s_strobe_min; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too short");
  property p_in_cs; (!rd_n || !rd_wr_n || !(&byte_enable_n)) |-> cs_on; endproperty
  a_in_cs: assert property (p_in_cs) else $error("strobe outside select");
  property p_refuse;
    (req_valid && req_ready && clk_en && req_area == 2'd3) |=> s_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad area not refused");
  property p_rsv_bcr;
    rd_acc && paddr == 8'h04 |-> (prdata & ~`EAB_BCR_MASK) == 32'h0;
  endproperty
  a_rsv_bcr: assert property (p_rsv_bcr) else $error("reserved bus bits set");
  property p_rsv_wcr;
    rd_acc && paddr == 8'h0c |-> (prdata & ~`EAB_WCR0_MASK) == 32'h0;
  endproperty
  a_rsv_wcr: assert property (p_rsv_wcr) else $error("reserved wait bits set");
  property p_pin; rd_acc && paddr == 8'h00 |-> prdata[10:9] == {!area0_width_pin, area0_width_pin};
  endproperty
  a_pin: assert property (p_pin) else $error("area 0 width wrong");
  // Write data is driven across every write strobe, inside the select and never with a read.
  property p_oe; (!rd_wr_n |-> ext_wdata_oe) and (ext_wdata_oe |-> cs_on && rd_n);
  endproperty
  a_oe: assert property (p_oe) else $error("write data drive out of place");
endmodule
bind eab_ctrl eab_ctrl_properties eab_ctrl_properties_i (.ref_clk, .reset_n, .clk_en, .psel,
  .penable, .pwrite, .paddr, .prdata, .area0_width_pin, .req_valid, .req_area, .req_ready,
  .resp_error, .ext_wdata_oe, .area_chip_select_n, .rd_n, .rd_wr_n, .byte_enable_n);

// ===== test/eab_mem_model.sv
/* Asynchronous 16-bit memory with byte lanes and a wait output.
   Assumes active-low strobes and selects from the controller. */
`timescale 1ns/1ps
module eab_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [25:0] ext_addr,
  input  wire logic [15:0] ext_wdata,
  input  wire logic [2:0]  area_chip_select_n,
  input  wire logic        rd_n,
  input  wire logic        rd_wr_n,
  input  wire logic [1:0]  byte_enable_n,
  input  wire logic [3:0]  stall,
  output logic      [15:0] ext_rdata,
  output logic             ext_wait
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0;
  logic        rd_q = 1'b1;
  logic [3:0]  cnt = 4'h0;
  wire logic   sel = ~&area_chip_select_n;
  // Data is driven only in a read strobe; otherwise the bus shows the inverse of the last word.
  assign ext_rdata = (sel && !rd_n) ? mem[ext_addr[3:0]] : ~last;
  assign ext_wait = !rd_n && (rd_q ? (stall != 4'h0) : (cnt != 4'h0));
  // Counts stall clocks from the strobe start and stores lanes under write strobe.
  always @(posedge ref_clk) begin
    rd_q <= rd_n;
    if (sel && !rd_n) begin
      last <= mem[ext_addr[3:0]];
      cnt <= rd_q ? stall - 4'(stall != 4'h0) : cnt - 4'(cnt != 4'h0);
    end
    if (sel && !rd_wr_n && !byte_enable_n[0]) mem[ext_addr[3:0]][7:0] <= ext_wdata[7:0];
    if (sel && !rd_wr_n && !byte_enable_n[1]) mem[ext_addr[3:0]][15:8] <= ext_wdata[15:8];
  end
endmodule

// ===== test/external_area_bus_timing_config_test.sv
/* Self-checking bench for eab_ctrl with an external memory model.
   Assumes a 200 MHz clock and zero-wait APB answers. */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module external_area_bus_timing_config_test;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [1:0]  req_area = 2'd0;
  logic [25:0] req_addr = 26'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [3:0]  stall = 4'h0;
  logic        width_pin = 1'b1;
  logic [31:0] prdata, q;
  logic [15:0] resp_rdata, ext_wdata, ext_rdata, d;
  logic [25:0] ext_addr;
  logic [2:0]  area_chip_select_n;
  logic [1:0]  byte_enable_n;
  logic        pready, pslverr, req_ready, resp_valid, resp_error, e;
  logic        ext_wdata_oe, ext_wait, rd_n, rd_wr_n;
  int          fails = 0;
  int          tests_run = 0;
  int          lat;
  logic [3:0]  ty[5] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'hf};
  logic [31:0] rst[6] = '{32'h00db0200, 32'h00db0600, 32'h00db0600, 32'h500, 32'h500, 32'h500};
  logic [31:0] ones[6] = '{32'h00dbf200, 32'h00dbf600, 32'h00dbf600, 32'h1fc3, 32'h1007c0,
                           32'h171fc3};
  // Clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;
  // Controller and memory.
  eab_ctrl eab_ctrl_i (
    .ref_clk, .reset_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .area0_width_pin(width_pin), .req_valid, .req_write,
    .req_area, .req_addr, .req_wdata, .req_bytes(2'b11), .req_ready, .resp_valid,
    .resp_rdata, .resp_error, .ext_addr, .ext_wdata, .ext_wdata_oe, .ext_rdata,
    .ext_wait, .area_chip_select_n, .rd_n, .rd_wr_n, .byte_enable_n
  );
  eab_mem_model eab_mem_model_i (
    .ref_clk, .ext_addr, .ext_wdata, .area_chip_select_n, .rd_n, .rd_wr_n,
    .byte_enable_n, .stall, .ext_rdata, .ext_wait
  );
  // Field packing, idle codes and expected access latency in clocks.
  function automatic logic [31:0] bcr(input logic [1:0] iws, iro, irs,
                                      input logic [3:0] t, input logic [1:0] w);
    return {8'h00, iws, 1'b0, iro, 1'b0, irs, t, 1'b0, w, 9'h000};
  endfunction
  function automatic logic [31:0] wcr(input logic byte_strobe_role_select, input logic [2:0] ww,
                                      input logic [1:0] sw, input logic [3:0] wr,
                                      input logic wm, input logic [1:0] hw);
    return {11'h000, byte_strobe_role_select, 1'b0, ww, 3'h0, sw, wr, wm, 4'h0, hw};
  endfunction
  function automatic int gap(int x); return (x % 4 == 3) ? 4 : x % 4; endfunction
  function automatic int tl(int g, int sw, logic [3:0] wr, int hw);
    int w;
    w = (wr < 4'd7) ? int'(wr) : (wr < 4'd11) ? 2 * int'(wr) - 6 : (wr == 4'd11) ? 18 : 24;
    return 2 * g + 2 * sw + 2 * w + 2 * hw + 5;
  endfunction
  // APB transfer, register setup and one memory access.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input int n, input logic [31:0] b, input logic [31:0] w);
    apb(1'b1, 8'(4 * n), b);
    apb(1'b1, 8'(4 * n + 12), w);
  endtask
  task automatic acc(input logic w, input logic [1:0] ar, input logic [15:0] wd);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_area <= ar;
    req_addr <= {22'h0, ar, 2'b00};
    req_wdata <= wd;
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge ref_clk);
      lat++;
    end while (resp_valid !== 1'b1 && resp_error !== 1'b1);
    e = resp_error;
    d = resp_rdata;
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK(q, rst[i])
      apb(1'b1, 8'(4 * i), 32'hffffffff);
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK(q, ones[i])
    end
    apb(1'b1, 8'h1c, 32'hffffffff);
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({e, q}, 33'h100000000)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(q, 32'h00000006)
    foreach (ty[k]) begin
      cfg(1, bcr(0, 0, 0, ty[k], 2'b10), 32'h0);
      acc(1'b1, 2'd1, 16'h0);
      `CHK(e, 1'b1)
    end
    acc(1'b1, 2'd3, 16'h0);
    `CHK(e, 1'b1)
    for (int c = 0; c < 13; c++) begin
      cfg(0, bcr(0, 0, 0, 4'h0, 2'b10), wcr(0, 0, 2'(c), 4'(c), 1'b1, 2'(c + 1)));
      acc(1'b0, 2'd0, 16'h0);
      `CHK(lat, tl(0, c % 4, 4'(c), (c + 1) % 4))
      acc(1'b1, 2'd0, 16'h0);
      `CHK(lat, tl(0, c % 4, 4'(c), (c + 1) % 4))
    end
    for (int m = 0; m < 2; m++) begin
      cfg(0, bcr(0, 0, 0, 4'h0, 2'b01), wcr(0, 0, 2'd0, 4'd0, 1'(m), 2'd0));
      stall <= 4'd3;
      acc(1'b0, 2'd0, 16'h0);
      `CHK(lat == 5, m == 1)
    end
    stall <= 4'd0;
    cfg(2, bcr(0, 0, 0, 4'h0, 2'b10), wcr(0, 3'd3, 2'd0, 4'd12, 1'b1, 2'd0));
    acc(1'b1, 2'd2, 16'h5a3c);
    `CHK(lat, tl(0, 0, 4'd2, 0))
    acc(1'b0, 2'd2, 16'h0);
    `CHK({d, lat}, {16'h5a3c, tl(0, 0, 4'd12, 0)})
    cfg(2, bcr(0, 0, 0, 4'h0, 2'b10), wcr(0, 3'd0, 2'd0, 4'd2, 1'b1, 2'd0));
    acc(1'b1, 2'd2, 16'h0ff0);
    `CHK(lat, tl(0, 0, 4'd2, 0))
    for (int r = 0; r < 3; r++) begin
      cfg(1, bcr(0, 0, 0, 4'h3, r == 2 ? 2'b01 : 2'b10), wcr(1'(r), 0, 0, 4'd1, 1'b1, 0));
      acc(1'b1, 2'd1, {r == 2 ? 8'h3c : 8'hc3, 8'ha5 + 8'(r)});
      acc(1'b0, 2'd1, 16'h0);
      `CHK(d[7:0], 8'ha5 + 8'(r))
      `CHK(d[15:8], 8'hc3)
    end
    cfg(2, bcr(0, 0, 0, 4'h0, 2'b10), wcr(0, 3'd0, 2'd0, 4'd0, 1'b1, 2'd0));
    for (int c = 0; c < 4; c++) begin
      cfg(0, bcr(2'(c), 2'(c + 1), 2'(c + 2), 4'h0, 2'b01), wcr(0, 0, 0, 4'd0, 1'b1, 0));
      acc(1'b0, 2'd0, 16'h0);
      acc(1'b0, 2'd0, 16'h0);
      `CHK(lat, tl(gap(c + 2), 0, 4'd0, 0))
      acc(1'b1, 2'd0, 16'h0);
      `CHK(lat, tl(gap(c), 0, 4'd0, 0))
      acc(1'b0, 2'd0, 16'h0);
      acc(1'b0, 2'd2, 16'h0);
      `CHK(lat, tl(gap(c + 1), 0, 4'd0, 0))
    end
    // Second reset with the width pin low: area 0 comes up 16 bits wide, fields at reset.
    @(posedge ref_clk);
    reset_n <= 1'b0;
    width_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h00db0400)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(q, 32'h00000004)
    report_and_stop;
  end
  // Watchdog against a hung handshake.
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule
